/* File: include/sgwl_defs.svh */
// Constants for the serial gain word loader: widths, reset values, gain steps.
// Assumes inclusion by bare name from the design files.
`ifndef SGWL_DEFS_SVH
`define SGWL_DEFS_SVH

`define SGWL_WORD_BITS 8
`define SGWL_GAIN_RESET 8'h00
`define SGWL_CNT_BITS 4
// Gain in hundredths of a dB
`define SGWL_GAIN_MIN_CDB 16'shF8E8
`define SGWL_GAIN_STEP_CDB 16'sh025A
`define SGWL_GAIN_TOP_CDB 16'sh0BB8

`endif

/* File: include/sgwl_pkg.sv */
// Types shared by the serial gain word loader files.
// Assumes nothing beyond a SystemVerilog compiler.
package sgwl_pkg;
    typedef logic [7:0] sgwl_code_t;
    typedef logic signed [15:0] sgwl_cdb_t;
    typedef enum logic [1:0] {SGWL_IDLE, SGWL_SHIFT} sgwl_state_t;
endpackage

/* File: logic/sgwl_sync.sv */
// Two-flop synchroniser for one pin level.
// Assumes a single clock; pin may change at any time.
`timescale 1ns/1ps
`default_nettype none
module sgwl_sync #(
    parameter logic RESET_VAL = 1'b0
) (
    input wire logic clock,
    input wire logic reset_n,
    input wire logic pin_in,
    output logic pin_sync
);
    logic meta_r;
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            meta_r <= RESET_VAL;
            pin_sync <= RESET_VAL;
        end else begin
            meta_r <= pin_in;
            pin_sync <= meta_r;
        end
    end
endmodule // sgwl_sync
`default_nettype wire

/* File: logic/sgwl_top.sv */
// Serial gain word loader: three-wire gain port plus transmit and sleep gates.
// Assumes all pins asynchronous to clock; serial clock far slower than clock.
//
// Function
// - A gain update needs at least eight serial bits; the register keeps the last eight.
// - Serial clock is honoured only after load window falls.
// - Data sampled on serial clock rise, most significant bit first.
// - Load window rise copies the shift word into the gain latch.
// - Code zero is -18.16 dB; bit i of bits 0-6 adds (i+1) x 6.02 dB; top 30.
// - Window high blocks shifting; window low holds previous gain.
// - Power-up latched gain code is zero until a full frame.
// - Transmit gate low disables transmission; high enables it.
// - Sleep low selects lowest power; high restores normal operation.
`timescale 1ns/1ps
`default_nettype none
`include "sgwl_defs.svh"
module sgwl_top #(
    parameter int WORD_BITS = `SGWL_WORD_BITS
) (
    input wire logic clock,
    input wire logic reset_n,
    input wire logic serial_clk,
    input wire logic serial_gain_in,
    input wire logic load_window_n,
    input wire logic transmit_gate,
    input wire logic sleep_n,
    output sgwl_pkg::sgwl_code_t gain_code,
    output sgwl_pkg::sgwl_cdb_t gain_cdb,
    output logic gain_update,
    output logic tx_enabled,
    output logic low_power
);
    import sgwl_pkg::*;

    // Shift slice and counter are sized for one byte only
    if (WORD_BITS != 8) begin : g_width_check
        $error("WORD_BITS must be 8");
    end

    logic sclk_s, sdat_s, win_s, txg_s, slp_s;
    sgwl_sync #(.RESET_VAL(1'b0)) u_sclk (.clock(clock), .reset_n(reset_n),
        .pin_in(serial_clk), .pin_sync(sclk_s));
    sgwl_sync #(.RESET_VAL(1'b0)) u_sdat (.clock(clock), .reset_n(reset_n),
        .pin_in(serial_gain_in), .pin_sync(sdat_s));
    sgwl_sync #(.RESET_VAL(1'b1)) u_win (.clock(clock), .reset_n(reset_n),
        .pin_in(load_window_n), .pin_sync(win_s));
    sgwl_sync #(.RESET_VAL(1'b0)) u_txg (.clock(clock), .reset_n(reset_n),
        .pin_in(transmit_gate), .pin_sync(txg_s));
    sgwl_sync #(.RESET_VAL(1'b1)) u_slp (.clock(clock), .reset_n(reset_n),
        .pin_in(sleep_n), .pin_sync(slp_s));

    logic sclk_d_r, win_d_r, sdat_d_r;
    sgwl_state_t state_r, state_nxt;
    sgwl_code_t shift_r, shift_nxt;
    logic [`SGWL_CNT_BITS-1:0] count_r, count_nxt;

    wire sclk_rise = sclk_s & ~sclk_d_r;
    wire win_fall = win_d_r & ~win_s;
    wire win_rise = ~win_d_r & win_s;
    wire shift_en = (state_r == SGWL_SHIFT) && !win_s && sclk_rise;
    // Eight bits complete a word; the count holds at eight after that
    wire word_full = (count_r == 4'(WORD_BITS));
    wire load_ok = win_rise && (state_r == SGWL_SHIFT) && word_full;

    // Gain per code, summed per bit weight
    function automatic sgwl_cdb_t code_to_cdb(sgwl_code_t c);
        sgwl_cdb_t g;
        g = `SGWL_GAIN_MIN_CDB;
        for (int i = 0; i < 7; i++) begin
            if (c[i]) begin
                g = sgwl_cdb_t'(g + (i + 1) * `SGWL_GAIN_STEP_CDB);
            end
        end
        // Top bit alone lands on the top gain; mixed codes only approximate
        if (c[7]) begin
            g = sgwl_cdb_t'(g + `SGWL_GAIN_TOP_CDB - `SGWL_GAIN_MIN_CDB);
        end
        return g;
    endfunction

    always_comb begin
        state_nxt = state_r;
        shift_nxt = shift_r;
        count_nxt = count_r;
        case (state_r)
            SGWL_IDLE: begin
                if (win_fall) begin
                    state_nxt = SGWL_SHIFT;
                    count_nxt = '0;
                end
            end
            SGWL_SHIFT: begin
                if (shift_en) begin
                    shift_nxt = {shift_r[6:0], sdat_d_r};
                    if (!word_full) begin
                        count_nxt = count_r + 4'h1;
                    end
                end
                if (win_rise) begin
                    state_nxt = SGWL_IDLE;
                end
            end
            default: begin
                state_nxt = SGWL_IDLE;
            end
        endcase
    end

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            sclk_d_r <= 1'b0;
            win_d_r <= 1'b1;
            sdat_d_r <= 1'b0;
            state_r <= SGWL_IDLE;
            shift_r <= '0;
            count_r <= '0;
        end else begin
            sclk_d_r <= sclk_s;
            win_d_r <= win_s;
            sdat_d_r <= sdat_s;
            state_r <= state_nxt;
            shift_r <= shift_nxt;
            count_r <= count_nxt;
        end
    end

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            gain_code <= `SGWL_GAIN_RESET;
            gain_cdb <= `SGWL_GAIN_MIN_CDB;
            gain_update <= 1'b0;
        end else begin
            gain_update <= load_ok;
            if (load_ok) begin
                gain_code <= shift_r;
                gain_cdb <= code_to_cdb(shift_r);
            end
        end
    end

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            tx_enabled <= 1'b0;
            low_power <= 1'b0;
        end else begin
            tx_enabled <= txg_s;
            low_power <= ~slp_s;
        end
    end

    gain_hold_a: assert property (@(posedge clock) disable iff (!reset_n)
        !$past(load_ok) |-> $stable(gain_code))
        else $error("gain changed without load");
    load_copy_a: assert property (@(posedge clock) disable iff (!reset_n)
        load_ok |=> gain_code == $past(shift_r) && gain_update)
        else $error("load did not copy word");
    short_frame_a: assert property (@(posedge clock) disable iff (!reset_n)
        win_rise && !word_full |=> $stable(gain_code))
        else $error("short frame updated gain");
    no_shift_a: assert property (@(posedge clock) disable iff (!reset_n)
        win_s && !win_rise |=> $stable(shift_r))
        else $error("shift while window high");
    shift_msb_a: assert property (@(posedge clock) disable iff (!reset_n)
        shift_en |=> shift_r == {$past(shift_r[6:0]), $past(sdat_d_r)})
        else $error("bad shift order");
    frame_open_a: assert property (@(posedge clock) disable iff (!reset_n)
        state_r == SGWL_IDLE && !win_fall |=> state_r == SGWL_IDLE)
        else $error("frame opened without fall");
    tx_follow_a: assert property (@(posedge clock) disable iff (!reset_n)
        txg_s |=> tx_enabled)
        else $error("transmit not enabled");
    sleep_follow_a: assert property (@(posedge clock) disable iff (!reset_n)
        !slp_s |=> low_power)
        else $error("sleep not entered");
    gain_zero_a: assert property (@(posedge clock) disable iff (!reset_n)
        gain_code == 8'h00 |-> gain_cdb == `SGWL_GAIN_MIN_CDB)
        else $error("code zero gain wrong");
    // Load steps: full frame closes, then a single pulse
    sequence full_close_s;
        win_rise && (state_r == SGWL_SHIFT) && word_full;
    endsequence
    sequence one_pulse_s;
        gain_update ##1 !gain_update;
    endsequence
    update_pulse_a: assert property (@(posedge clock) disable iff (!reset_n)
        full_close_s |=> one_pulse_s)
        else $error("update pulse wrong");
    sequence open_frame_s;
        (state_r == SGWL_IDLE) && win_fall;
    endsequence
    frame_start_a: assert property (@(posedge clock) disable iff (!reset_n)
        open_frame_s |=> (state_r == SGWL_SHIFT) && (count_r == 4'h0))
        else $error("frame did not open");
    bit_count_a: assert property (@(posedge clock) disable iff (!reset_n)
        shift_en && !word_full |=> count_r == $past(count_r) + 4'h1)
        else $error("bit count wrong");
    gain_top_a: assert property (@(posedge clock) disable iff (!reset_n)
        gain_code == 8'h80 |-> gain_cdb == `SGWL_GAIN_TOP_CDB)
        else $error("top code gain wrong");
    gain_one_a: assert property (@(posedge clock) disable iff (!reset_n)
        gain_code == 8'h01 |-> gain_cdb == sgwl_cdb_t'(`SGWL_GAIN_MIN_CDB + `SGWL_GAIN_STEP_CDB))
        else $error("low bit gain wrong");
    tx_block_a: assert property (@(posedge clock) disable iff (!reset_n)
        !txg_s |=> !tx_enabled)
        else $error("transmit not disabled");
    sleep_exit_a: assert property (@(posedge clock) disable iff (!reset_n)
        slp_s |=> !low_power)
        else $error("sleep not left");
endmodule // sgwl_top
`default_nettype wire

/* File: tb/sgwl_host.sv */
// Host model: drives the three serial control lines of the gain port.
// Assumes the caller starts each frame with the link idle.
`timescale 1ns/1ps
`default_nettype none
module sgwl_host (
    output logic serial_clk,
    output logic serial_gain_in,
    output logic load_window_n
);
    initial begin
        serial_clk = 1'b0;
        serial_gain_in = 1'b0;
        load_window_n = 1'b1;
    end
    // Sends n bits of w; gated keeps the window high throughout
    task automatic send(input logic [7:0] w, input int n, input bit gated);
        load_window_n = gated;
        #40;
        for (int i = 0; i < n; i++) begin
            serial_gain_in = w[7 - i];
            #40 serial_clk = 1'b1;
            #40 serial_clk = 1'b0;
        end
        #40 load_window_n = 1'b1;
        // No pull on data: show inverse once released
        serial_gain_in = ~serial_gain_in;
        #80;
    endtask
endmodule // sgwl_host
`default_nettype wire

/* File: tb/sgwl_top_tb.sv */
// Self-checking bench for the gain word loader.
// Assumes the host model owns the serial lines.
`timescale 1ns/1ps
`default_nettype none
`include "sgwl_defs.svh"
module sgwl_top_tb;
    import sgwl_pkg::*;
    logic clock = 1'b0;
    logic reset_n = 1'b0;
    logic transmit_gate = 1'b0;
    logic sleep_n = 1'b1;
    wire logic serial_clk;
    wire logic serial_gain_in;
    wire logic load_window_n;
    sgwl_code_t gain_code;
    sgwl_cdb_t gain_cdb;
    logic gain_update;
    logic tx_enabled;
    logic low_power;
    int errors = 0;
    int n_compared = 0;
    logic [31:0] seed = 32'h0000_0005;
    sgwl_code_t exp_q[$];
    sgwl_code_t last_code = 8'h00;
    sgwl_code_t mon_code;
    always #4 clock = ~clock;
    sgwl_host i_sgwl_host (.serial_clk(serial_clk), .serial_gain_in(serial_gain_in),
        .load_window_n(load_window_n));
    sgwl_top #(.WORD_BITS(8)) i_sgwl_top (.clock(clock), .reset_n(reset_n),
        .serial_clk(serial_clk), .serial_gain_in(serial_gain_in),
        .load_window_n(load_window_n), .transmit_gate(transmit_gate), .sleep_n(sleep_n),
        .gain_code(gain_code), .gain_cdb(gain_cdb), .gain_update(gain_update),
        .tx_enabled(tx_enabled), .low_power(low_power));
    function automatic logic [31:0] xs(input logic [31:0] s);
        s ^= s << 13;
        s ^= s >> 17;
        s ^= s << 5;
        return s;
    endfunction
    // Exact for every code with bit 7 clear and for code 0x80 alone
    function automatic logic [15:0] cdb_of(input sgwl_code_t c);
        int v;
        v = `SGWL_GAIN_MIN_CDB;
        for (int i = 0; i < 7; i++) if (c[i]) v += `SGWL_GAIN_STEP_CDB * (i + 1);
        if (c[7]) v = `SGWL_GAIN_TOP_CDB;
        return v[15:0];
    endfunction
    task automatic cmp(input string nm, input logic [15:0] e, input logic [15:0] g);
        n_compared++;
        if (g !== e) begin
            errors++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic complete_run;
        if (errors == 0 && n_compared > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    // Only a whole open frame expects a latch
    task automatic frame(input sgwl_code_t w, input int n, input bit gated);
        if (n == 8 && !gated) begin
            exp_q.push_back(w);
            last_code = w;
        end
        i_sgwl_host.send(w, n, gated);
        @(posedge clock);
        #1;
        cmp("gain_code", {8'h00, last_code}, {8'h00, gain_code});
    endtask
    always @(negedge clock) begin
        if (gain_update === 1'b1) begin
            if (exp_q.size() == 0) begin
                cmp("gain_update", 16'h0000, 16'h0001);
            end else begin
                mon_code = exp_q.pop_front();
                cmp("gain_code", {8'h00, mon_code}, {8'h00, gain_code});
                cmp("gain_cdb", cdb_of(mon_code), gain_cdb);
            end
        end
    end
    initial begin
        repeat (5) @(posedge clock);
        #1 reset_n = 1'b1;
        repeat (3) @(posedge clock);
        #1;
        cmp("gain_code", 16'h0000, {8'h00, gain_code});
        cmp("gain_cdb", cdb_of(8'h00), gain_cdb);
        for (int i = 0; i < 9; i++) frame(sgwl_code_t'(8'h01 << i), 8, 1'b0);
        frame(8'h5A, 5, 1'b0);
        frame(8'h81, 8, 1'b1);
        for (int k = 0; k < 12; k++) begin
            seed = xs(seed);
            @(posedge clock);
            #1;
            transmit_gate = seed[8];
            sleep_n = seed[9];
            frame(sgwl_code_t'(8'h01 << seed[2:0]), 8, 1'b0);
            cmp("tx_enabled", {15'h0000, seed[8]}, {15'h0000, tx_enabled});
            cmp("low_power", {15'h0000, ~seed[9]}, {15'h0000, low_power});
        end
        cmp("pending", 16'h0000, 16'(exp_q.size()));
        complete_run;
    end
    initial begin
        #100000;
        errors++;
        complete_run;
    end
endmodule // sgwl_top_tb
`default_nettype wire
